// *** design/tpw_top.sv ***
// Timer PWM output units, pin routing, counter and register slave
`timescale 1ns/10ps
module tpw_top #(
  parameter int NCHAN = tpw_pkg::NCH
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic [31:0]              hwdata_i,
  input  wire logic                     hready_i,
  output logic      [31:0]              hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  input  wire logic [tpw_pkg::NPIN-1:0] pin_i,
  output logic      [tpw_pkg::NPIN-1:0] pin_o,
  output logic      [tpw_pkg::NPIN-1:0] pin_oe_o,
  input  wire logic [tpw_pkg::NPIN-1:0] port_out_i,
  input  wire logic [tpw_pkg::NPIN-1:0] port_oe_i,
  output logic      [tpw_pkg::NPIN-1:0] port_in_o
);
  import tpw_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] slot(input logic [7:0] base, input int idx);
    slot = base + 8'(idx * 4);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tpw_cmode_t         cmode_ff;
  logic               ext_ff;
  logic               ovie_ff;
  logic               ovfl_ff;
  logic [CW-1:0]      cnt_ff;
  logic               dir_up_ff;
  logic               hit_ff;
  logic [NPIN-1:0]    pinsel_ff;
  logic [CW-1:0]      ccr_ff   [NCHAN];
  tpw_omode_t         omode_ff [NCHAN];
  logic [NCHAN-1:0]   outbit_ff;
  logic [NCHAN-1:0]   cap_ff;
  logic [NCHAN-1:0]   ie_ff;
  logic [NCHAN-1:0]   flag_ff;
  logic [NPIN-1:0]    sync1_ff;
  logic [NPIN-1:0]    sync2_ff;
  logic [NPIN-1:0]    sync3_ff;
  logic [NPIN-1:0]    lvl_ff;
  logic               dph_ff;
  logic               dwr_ff;
  logic [7:0]         daddr_ff;
  logic [31:0]        rdata_ff;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire              aph_take = hsel_i & hready_i & htrans_i[1];
  wire              rd_take  = aph_take & ~hwrite_i;
  wire              wr_ph    = dph_ff & dwr_ff;
  wire              wr_ctrl  = wr_ph & (daddr_ff == OFS_CTRL);
  wire              wr_psel  = wr_ph & (daddr_ff == OFS_PINSEL);
  wire              rd_iv    = rd_take & (haddr_i[7:0] == OFS_IVEC) & (haddr_i[31:8] == 24'h000000);
  wire              sw_clear = wr_ctrl & hwdata_i[CTRL_CLR];
  logic [NCHAN-1:0] wr_cctl;
  logic [NCHAN-1:0] wr_ccr;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      wr_cctl[i] = wr_ph & (daddr_ff == slot(OFS_CCTL0, i));
      wr_ccr[i]  = wr_ph & (daddr_ff == slot(OFS_PERIOD_COMPARE_VALUE, i));
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [NPIN-1:0] lvl_agree = ~(sync2_ff ^ sync3_ff);
  wire [NPIN-1:0] nxt_lvl   = (lvl_ff & ~lvl_agree) | (sync3_ff & lvl_agree);
  wire [NPIN-1:0] rise      = nxt_lvl & ~lvl_ff;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      lvl_ff   <= '0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff   <= nxt_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // clock pin used when selected
  wire            ext_ok  = pinsel_ff[PIN_CLK] & rise[PIN_CLK];
  wire            running = (cmode_ff != CM_STOP);
  wire            tick    = running & (ext_ff ? ext_ok : 1'b1);
  wire [CW-1:0]   per     = ccr_ff[0];
  wire            at_per  = (cnt_ff >= per);
  logic [CW-1:0]  nxt_cnt;
  logic           nxt_dir;
  logic           ovf_evt;

  // up mode counts 0 to the period value per, then wraps to 0
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_up_ff;
    ovf_evt = 1'b0;
    if (tick) begin
      case (cmode_ff)
        CM_UP: begin
          nxt_cnt = at_per ? '0 : CW'(cnt_ff + 1'b1);
          ovf_evt = at_per;
        end
        CM_CONT: begin
          nxt_cnt = CW'(cnt_ff + 1'b1);
          ovf_evt = (cnt_ff == CNT_MAX);
        end
        CM_UPDN: begin
          if (dir_up_ff) begin
            nxt_cnt = at_per ? CW'(cnt_ff - 1'b1) : CW'(cnt_ff + 1'b1);
            nxt_dir = ~at_per;
          end else begin
            nxt_cnt = (cnt_ff == '0) ? CW'(1) : CW'(cnt_ff - 1'b1);
            nxt_dir = (cnt_ff <= CW'(1));
            ovf_evt = (cnt_ff == CW'(1));
          end
        end
        default: begin
          nxt_cnt = cnt_ff;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || sw_clear) begin
      cnt_ff    <= '0;
      dir_up_ff <= 1'b1;
      hit_ff    <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      dir_up_ff <= nxt_dir;
      hit_ff    <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Equality and capture events
  // ----------------------------------------------------------------
  wire              is_up = (cmode_ff == CM_UP);
  wire              cmp0  = hit_ff & (cnt_ff == per);
  // period equality: wrap to zero in up mode (nonzero period), count equal to per in other modes
  wire              period_equal  = is_up ? (hit_ff & (cnt_ff == '0) & (per != '0)) : cmp0;
  logic [NCHAN-1:0] equ;
  logic [NCHAN-1:0] flag_set;
  logic [NCHAN-1:0] cap_evt;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      equ[i]     = (i == 0) ? period_equal : (hit_ff & (cnt_ff == ccr_ff[i]));
      cap_evt[i] = cap_ff[i] & pinsel_ff[PIN_CH0 + i] & rise[PIN_CH0 + i];
      // in up mode, no flag for zero or above period
      if (cap_ff[i]) begin
        flag_set[i] = cap_evt[i];
      end else if (i == 0) begin
        flag_set[i] = cmp0;
      end else begin
        flag_set[i] = equ[i] & ~(is_up & (ccr_ff[i] == '0));
      end
    end
  end

  // ----------------------------------------------------------------
  // Vector word
  // ----------------------------------------------------------------
  logic [3:0]       iv_code;
  logic [NCHAN-1:0] iv_clr;

  always_comb begin
    iv_code = IV_NONE;
    if (ovfl_ff && ovie_ff) begin
      iv_code = IV_OVF;
    end
    for (int i = NCHAN - 1; i >= 1; i--) begin
      if (flag_ff[i] && ie_ff[i]) begin
        iv_code = 4'(2 * i);
      end
    end
    for (int i = 0; i < NCHAN; i++) begin
      iv_clr[i] = rd_iv & (i != 0) & (iv_code == 4'(2 * i));
    end
  end

  wire ov_clr = (rd_iv & (iv_code == IV_OVF)) | (wr_ctrl & hwdata_i[CTRL_OVFL]);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmode_ff  <= CM_STOP;
      ext_ff    <= 1'b0;
      ovie_ff   <= 1'b0;
      ovfl_ff   <= 1'b0;
      pinsel_ff <= RST_PINSEL;
    end else begin
      if (wr_ctrl) begin
        cmode_ff <= tpw_cmode_t'(hwdata_i[CTRL_MODE +: 2]);
        ext_ff   <= hwdata_i[CTRL_EXT];
        ovie_ff  <= hwdata_i[CTRL_OVIE];
      end
      ovfl_ff <= ovf_evt | (ovfl_ff & ~ov_clr);
      // one select bit per shared pin
      if (wr_psel) begin
        pinsel_ff <= {hwdata_i[NPIN-1:PIN_CLK], 2'b00};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        ccr_ff[i]   <= RST_CCR;
        omode_ff[i] <= OM_BIT;
      end
      outbit_ff <= '0;
      cap_ff    <= '0;
      ie_ff     <= '0;
      flag_ff   <= '0;
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        if (wr_cctl[i]) begin
          omode_ff[i]  <= tpw_omode_t'(hwdata_i[CCTL_MODE +: 3]);
          outbit_ff[i] <= hwdata_i[CCTL_OUT];
          cap_ff[i]    <= hwdata_i[CCTL_CAP];
          ie_ff[i]     <= hwdata_i[CCTL_IE];
        end
        if (wr_ccr[i]) begin
          ccr_ff[i] <= hwdata_i[CW-1:0];
        end else if (cap_evt[i]) begin
          ccr_ff[i] <= cnt_ff;
        end
        // Event wins over a clear in the same cycle
        flag_ff[i] <= flag_set[i] |
                      (flag_ff[i] & ~iv_clr[i] & ~(wr_cctl[i] & hwdata_i[CCTL_FLAG]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Output units
  // ----------------------------------------------------------------
  logic [NCHAN-1:0] chan_out;

  for (genvar g = 0; g < NCHAN; g++) begin : g_unit
    tpw_out_unit u_unit (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .mode_i    (omode_ff[g]),
      .out_bit_i (outbit_ff[g]),
      .equ_x_i   (equ[g]),
      .equ_0_i   (period_equal),
      .out_o     (chan_out[g])
    );
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    if (p >= PIN_CH0 && p < PIN_CH0 + NCHAN) begin : g_ch
      wire drv = pinsel_ff[p] & ~cap_ff[p - PIN_CH0];
      assign pin_o[p]    = pinsel_ff[p] ? (drv & chan_out[p - PIN_CH0]) : port_out_i[p];
      assign pin_oe_o[p] = pinsel_ff[p] ? drv : port_oe_i[p];
    end else begin : g_port
      assign pin_o[p]    = pinsel_ff[p] ? 1'b0 : port_out_i[p];
      assign pin_oe_o[p] = pinsel_ff[p] ? 1'b0 : port_oe_i[p];
    end
  end

  assign port_in_o = pin_i;

  // ----------------------------------------------------------------
  // Read data and bus handshake
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr_i[31:8] == 24'h000000) begin
      case (haddr_i[7:0])
        OFS_CTRL:   rd_word = {26'h0, ovfl_ff, ovie_ff, 1'b0, ext_ff, cmode_ff};
        OFS_COUNT:  rd_word = {16'h0000, cnt_ff};
        OFS_IVEC:   rd_word = {28'h0000000, iv_code};
        OFS_PINSEL: rd_word = {24'h000000, pinsel_ff};
        default: begin
          for (int i = 0; i < NCHAN; i++) begin
            if (haddr_i[7:0] == slot(OFS_CCTL0, i)) begin
              rd_word = {22'h0, chan_out[i], cap_ff[i], 2'b00, omode_ff[i],
                         outbit_ff[i], ie_ff[i], flag_ff[i]};
            end
            if (haddr_i[7:0] == slot(OFS_PERIOD_COMPARE_VALUE, i)) begin
              rd_word = {16'h0000, ccr_ff[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dph_ff   <= 1'b0;
      dwr_ff   <= 1'b0;
      daddr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      dph_ff   <= aph_take & (haddr_i[31:8] == 24'h000000) & (hsize_i == 3'h2);
      dwr_ff   <= hwrite_i;
      daddr_ff <= haddr_i[7:0];
      if (rd_take) begin
        rdata_ff <= rd_word;
      end
    end
  end

  assign hrdata_o    = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule

// *** design/tpw_pkg.sv ***
// Shared constants and types for the timer PWM output and pin-select block
package tpw_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH     = 5;
  localparam int NPIN    = 8;
  localparam int CW      = 16;
  localparam int PIN_CLK = 2;
  localparam int PIN_CH0 = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_IVEC   = 8'h08;
  localparam logic [7:0] OFS_PINSEL = 8'h0C;
  localparam logic [7:0] OFS_CCTL0  = 8'h10;
  localparam logic [7:0] OFS_PERIOD_COMPARE_VALUE   = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE = 0;
  localparam int CTRL_EXT  = 2;
  localparam int CTRL_CLR  = 3;
  localparam int CTRL_OVIE = 4;
  localparam int CTRL_OVFL = 5;
  localparam int CCTL_FLAG = 0;
  localparam int CCTL_IE   = 1;
  localparam int CCTL_OUT  = 2;
  localparam int CCTL_MODE = 3;
  localparam int CCTL_CAP  = 8;
  localparam int CCTL_LVL  = 9;

  // ----------------------------------------------------------------
  // Reset values and vector codes
  // ----------------------------------------------------------------
  localparam logic [CW-1:0]   RST_CCR    = 16'h0000;
  localparam logic [CW-1:0]   CNT_MAX    = 16'hFFFF;
  localparam logic [NPIN-1:0] RST_PINSEL = 8'h00;
  localparam logic [3:0]      IV_NONE    = 4'h0;
  localparam logic [3:0]      IV_OVF     = 4'hA;

  typedef enum logic [1:0] {
    CM_STOP = 2'b00,
    CM_UP   = 2'b01,
    CM_CONT = 2'b10,
    CM_UPDN = 2'b11
  } tpw_cmode_t;

  typedef enum logic [2:0] {
    OM_BIT    = 3'h0,
    OM_SET    = 3'h1,
    OM_TGLRST = 3'h2,
    OM_SETRST = 3'h3,
    OM_TGL    = 3'h4,
    OM_RST    = 3'h5,
    OM_TGLSET = 3'h6,
    OM_RSTSET = 3'h7
  } tpw_omode_t;

endpackage

// *** design/tpw_out_unit.sv ***
// Output unit of one channel: eight modes driven by channel and period equality
`timescale 1ns/10ps
module tpw_out_unit (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire tpw_pkg::tpw_omode_t mode_i,
  input  wire logic               out_bit_i,
  input  wire logic               equ_x_i,
  input  wire logic               equ_0_i,
  output logic                    out_o
);
  import tpw_pkg::*;

  logic out_ff;
  logic nxt_out;

  always_comb begin
    nxt_out = out_ff;
    if (mode_i == OM_BIT) begin
      nxt_out = out_bit_i;
    end else if (equ_x_i && equ_0_i) begin
      case (mode_i)
        OM_SET, OM_TGLRST, OM_SETRST: nxt_out = 1'b1;
        OM_TGL:                       nxt_out = ~out_ff;
        default:                      nxt_out = 1'b0;
      endcase
    end else if (equ_x_i) begin
      case (mode_i)
        OM_SET, OM_SETRST:            nxt_out = 1'b1;
        OM_RST, OM_RSTSET:            nxt_out = 1'b0;
        default:                      nxt_out = ~out_ff;
      endcase
    end else if (equ_0_i) begin
      case (mode_i)
        OM_TGLRST, OM_SETRST:         nxt_out = 1'b0;
        OM_TGLSET, OM_RSTSET:         nxt_out = 1'b1;
        default:                      nxt_out = out_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign out_o = out_ff;

endmodule

// *** sim/tpw_top_asserts.sv ***
// Port-level assertions for the timer PWM output and pin-select block
`timescale 1ns/10ps
module tpw_top_asserts (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  port_out_i,
  input wire logic [7:0]  port_oe_i,
  input wire logic [7:0]  port_in_o
);
  import tpw_pkg::*;
  logic rd_take;
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_rd_taken;
    rd_take;
  endsequence
  sequence s_ivec_read;
    s_rd_taken ##0 (haddr_i == {24'h0, OFS_IVEC});
  endsequence
  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  // fixed port pins
  a_fixed_port: assert property (pin_o[1:0] == port_out_i[1:0] && pin_oe_o[1:0] == port_oe_i[1:0])
    else $error("fixed pin not routed to port logic");
  a_port_input: assert property (port_in_o == pin_i)
    else $error("port input differs from pin");
  a_reset_route: assert property (disable iff (1'b0) $fell(rst_i) |->
    pin_o == port_out_i && pin_oe_o == port_oe_i && hrdata_o == 32'h0)
    else $error("state after reset wrong");
  a_release_low: assert property ((~pin_oe_o & port_oe_i & pin_o) == 8'h00)
    else $error("timer input pin shows output value");
  a_clk_pin: assert property (pin_oe_o[PIN_CLK] |-> pin_o[PIN_CLK] == port_out_i[PIN_CLK] && port_oe_i[PIN_CLK])
    else $error("clock pin driven by timer");
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // vector codes only
  a_ivec_code: assert property (s_ivec_read |=> hrdata_o inside {32'h0, 32'h2, 32'h4, 32'h6, 32'h8, 32'hA})
    else $error("vector word has illegal code");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o))
    else $error("read data changed without read");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus response not ready okay");
endmodule
bind tpw_top tpw_top_asserts u_tpw_top_asserts (.mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .pin_i, .pin_o, .pin_oe_o, .port_out_i, .port_oe_i, .port_in_o);

// *** sim/tpw_pin_model.sv ***
// Pin-side model: external timer clock source and undriven line pattern
`timescale 1ns/10ps
module tpw_pin_model (
  input  wire logic       mclk_i,
  input  wire logic       clk_run_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  output logic      [7:0] pin_wire_o
);
  logic [7:0] src;
  logic [2:0] phase_ff;
  logic       alt_ff;
  initial begin
    phase_ff = 3'h0;
    alt_ff = 1'b0;
  end
  // Clock stands low outside bursts; free lines change every cycle
  always @(posedge mclk_i) begin
    alt_ff <= ~alt_ff;
    phase_ff <= clk_run_i ? phase_ff + 3'h1 : 3'h0;
  end
  // one rising edge per eight cycles on clock pin and channel 1 pin
  assign src = {{3{alt_ff}}, phase_ff[2], alt_ff, phase_ff[2], {2{alt_ff}}};
  assign pin_wire_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & src);
endmodule

// *** sim/tpw_top_tb.sv ***
// Self-checking bench for the timer PWM output and pin-select block
`timescale 1ns/10ps
module tpw_top_tb;
  import tpw_pkg::*;
  logic        mclk_i, rst_i, hsel, hwrite, hready, hresp, clk_run, rd_dph, win_on;
  logic [1:0]  htrans, smp;
  logic [31:0] haddr, hwdata, hrdata, hi_cnt;
  logic [7:0]  pin_i, pin_o, pin_oe, port_out, port_oe, port_in, sel, cap, ob, eo, ep;
  logic [31:0] exp_q[$];
  int          fail_count, num_checks, seed, i;
  int          tm[8] = '{7, 7, 7, 6, 3, 2, 4, 4};
  int          tc[8] = '{4, 0, 10, 4, 4, 4, 4, 12};
  int          tw[8] = '{8, 0, 20, 8, 12, 12, 20, 40};
  initial mclk_i = 1'b0;
  always #2.5 mclk_i = ~mclk_i;
  tpw_top u_tpw_top (.mclk_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .pin_i, .pin_o, .pin_oe_o(pin_oe), .port_out_i(port_out), .port_oe_i(port_oe),
    .port_in_o(port_in));
  tpw_pin_model u_tpw_pin_model (.mclk_i, .clk_run_i(clk_run), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pin_wire_o(pin_i));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic sample(input logic [1:0] kind, input logic [31:0] want);
    exp_q.push_back(want);
    smp <= kind;
    @(posedge mclk_i);
    smp <= 2'h0;
  endtask
  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    rd_dph <= hsel && htrans[1] && !hwrite && hready;
    if (win_on)
      hi_cnt <= hi_cnt + {31'h0, pin_o[4]};
    if (rd_dph)
      check(hrdata, exp_q.pop_front());
    if (smp == 2'h1)
      check({16'h0, pin_oe, pin_o}, exp_q.pop_front());
    if (smp == 2'h2)
      check(hi_cnt, exp_q.pop_front());
    if (smp == 2'h3)
      check({31'h0, pin_o[4]}, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 1;
    fail_count = 0;
    num_checks = 0;
    {hsel, hwrite, htrans, haddr, hwdata, clk_run, rd_dph, win_on, smp, hi_cnt} = '0;
    rst_i = 1'b1;
    port_out = $random(seed);
    port_oe = $random(seed);
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    sample(2'h1, {16'h0, port_oe, port_out});
    for (i = 0; i < 18; i++)
      rd((i < 17) ? 8'(i * 4) : 8'h80, 32'h0);
    $display("test reset values done");
    sel = $random(seed) & 8'hFC;
    cap = $random(seed) & 8'hF8;
    ob = $random(seed) & 8'hF8;
    ahb(1'b1, OFS_PINSEL, {24'h0, sel});
    rd(OFS_PINSEL, {24'h0, sel});
    for (i = 0; i < 5; i++)
      ahb(1'b1, OFS_CCTL0 + 8'(i * 4), {23'h0, cap[i + 3], 5'h0, ob[i + 3], 2'h0});
    port_out <= $random(seed);
    port_oe <= $random(seed);
    repeat (3) @(posedge mclk_i);
    for (i = 0; i < 8; i++) begin
      eo[i] = sel[i] ? (i > 2) && !cap[i] : port_oe[i];
      ep[i] = sel[i] ? (i > 2) && !cap[i] && ob[i] : port_out[i];
    end
    sample(2'h1, {16'h0, eo, ep});
    for (i = 0; i < 5; i++)
      ahb(1'b1, OFS_CCTL0 + 8'(i * 4), 32'h1);
    $display("test pin routing done");
    // up mode duty per output mode
    ahb(1'b1, OFS_PINSEL, 32'h10);
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE, 32'h9);
    for (i = 0; i < 8; i++) begin
      ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR);
      ahb(1'b1, OFS_CCTL0 + 8'h4, 32'h1 << CCTL_OUT);
      ahb(1'b1, OFS_CCTL0 + 8'h4, (32'(tm[i]) << CCTL_MODE) | 32'h3);
      ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'(tc[i]));
      ahb(1'b1, OFS_CTRL, 32'(CM_UP));
      repeat (25) @(posedge mclk_i);
      hi_cnt <= 32'h0;
      win_on <= 1'b1;
      repeat ((tm[i] == 4) ? 40 : 20) @(posedge mclk_i);
      win_on <= 1'b0;
      sample(2'h2, 32'(tw[i]));
      ahb(1'b1, OFS_CTRL, 32'h0);
      rd(OFS_IVEC, (tc[i] > 0 && tc[i] < 10) ? 32'h2 : 32'h0);
      rd(OFS_IVEC, 32'h0);
    end
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h4);
    ahb(1'b1, OFS_CTRL, (32'h1 << CTRL_OVIE) | 32'(CM_UP));
    repeat (30) @(posedge mclk_i);
    ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_OVIE);
    rd(OFS_IVEC, 32'h2);
    rd(OFS_IVEC, {28'h0, IV_OVF});
    rd(OFS_IVEC, {28'h0, IV_NONE});
    $display("test up mode pwm done");
    // continuous mode reaction to period equality
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h8000);
    for (i = 2; i < 5; i++) begin
      ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR);
      ahb(1'b1, OFS_CCTL0 + 8'h4, 32'h1 << CCTL_OUT);
      ahb(1'b1, OFS_CCTL0 + 8'h4, 32'(i) << CCTL_MODE);
      ahb(1'b1, OFS_CTRL, 32'(CM_CONT));
      repeat (20) @(posedge mclk_i);
      sample(2'h3, {31'h0, i == 4});
    end
    // single-register PWM by alternating set and reset
    ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR);
    ahb(1'b1, OFS_CCTL0 + 8'h4, 32'h0);
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h14);
    ahb(1'b1, OFS_CCTL0 + 8'h4, 32'(OM_SET) << CCTL_MODE);
    ahb(1'b1, OFS_CTRL, 32'(CM_CONT));
    repeat (30) @(posedge mclk_i);
    sample(2'h3, 32'h1);
    // handler switches the mode and advances the compare value by the interval
    ahb(1'b1, OFS_CCTL0 + 8'h4, 32'(OM_RST) << CCTL_MODE);
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h14 + 32'h1E);
    repeat (25) @(posedge mclk_i);
    sample(2'h3, 32'h0);
    // capture input on a selected channel pin
    ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR);
    ahb(1'b1, OFS_CCTL0 + 8'h4, (32'h1 << CCTL_CAP) | 32'h3);
    ahb(1'b1, OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h1234);
    clk_run <= 1'b1;
    repeat (8) @(posedge mclk_i);
    clk_run <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rd(OFS_PERIOD_COMPARE_VALUE + 8'h4, 32'h0);
    rd(OFS_IVEC, 32'h2);
    $display("test continuous mode and capture done");
    // external clock counts only when its pin is selected
    ahb(1'b1, OFS_PINSEL, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR);
    ahb(1'b1, OFS_CTRL, (32'h1 << CTRL_EXT) | 32'(CM_CONT));
    for (i = 0; i < 2; i++) begin
      clk_run <= 1'b1;
      repeat (40) @(posedge mclk_i);
      clk_run <= 1'b0;
      repeat (8) @(posedge mclk_i);
      rd(OFS_COUNT, 32'(i * 5));
      ahb(1'b1, OFS_PINSEL, 32'h1 << PIN_CLK);
    end
    $display("test external clock done");
    complete_run();
  end
endmodule
